// >>> logic/dqrt_pkg.sv
package dqrt_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ         = 200;
    localparam int ENTRY_DELAY_NS  = 150;
    localparam int EXIT_DELAY_NS   = 150;
    localparam int SETTLE_SHORT_NS = 80;
    localparam int SETTLE_LONG_NS  = 250;
    localparam int PDEV_DQ_NS      = 40;
    localparam int TMR_W           = 8;
    localparam logic [7:0] ENTRY_CYC = 8'((ENTRY_DELAY_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] EXIT_CYC  = 8'((EXIT_DELAY_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] SHORT_CYC = 8'((SETTLE_SHORT_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] LONG_CYC  = 8'((SETTLE_LONG_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] PDEV_CYC  = 8'((PDEV_DQ_NS * CLK_MHZ + 999) / 1000);
    // ------------------------------------------------------------
    // level codes and mode register layout
    // ------------------------------------------------------------
    localparam logic [5:0] LEVEL_MAX    = 6'h32;
    localparam logic [5:0] LONG_STEP    = 6'h04;
    localparam int         TREG_EN_BIT  = 7;
    localparam int         TREG_RNG_BIT = 6;
    localparam logic [1:0] TREG_BG      = 2'h1;
    localparam logic [1:0] TREG_BA      = 2'h2;
    localparam int         AP_BIT       = 10;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] REG_CMD    = 12'h000;
    localparam logic [11:0] REG_ADDR   = 12'h004;
    localparam logic [11:0] REG_PDEV   = 12'h008;
    localparam logic [11:0] REG_STATUS = 12'h00C;
    localparam int CMD_RANGE_BIT = 4;
    localparam int CMD_LEVEL_LSB = 8;
    localparam int CMD_BG_LSB    = 16;
    localparam int CMD_BA_LSB    = 18;
    localparam int PDEV_EN_BIT   = 0;
    localparam int PDEV_TGT_BIT  = 1;
    localparam int ST_TRAIN      = 0;
    localparam int ST_RANGE      = 1;
    localparam int ST_ENTRY_WAIT = 2;
    localparam int ST_SETTLE     = 3;
    localparam int ST_EXIT_WAIT  = 4;
    localparam int ST_VALID      = 5;
    localparam int ST_FIRST      = 6;
    localparam int ST_BANKS      = 7;
    localparam int ST_LEVEL_LSB  = 8;
    localparam int ST_ERR_REF    = 16;
    localparam int ST_ERR_RSV    = 17;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NONE, OP_ENTER, OP_LEVEL, OP_EXIT, OP_ACT,
        OP_WR, OP_WRA, OP_RD, OP_RDA, OP_PRE
    } dqrt_op_e;
    typedef enum logic [1:0] {M_NORMAL, M_ENTRY_WAIT, M_TRAIN, M_EXIT_WAIT} dqrt_mode_e;
    typedef struct packed {
        logic        cs_n;
        logic        act_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic [1:0]  bg;
        logic [1:0]  ba;
        logic [13:0] addr;
    } dqrt_ca_s;
    localparam dqrt_ca_s CA_IDLE = '{cs_n: 1'b1, act_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
                                     we_n: 1'b1, bg: 2'h0, ba: 2'h0, addr: 14'h0000};
endpackage

// >>> logic/dqrt_timer.sv
`timescale 1ns/1ps
module dqrt_timer
    import dqrt_pkg::*;
#(
    parameter int W = TMR_W
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         load,
    input  wire logic [W-1:0] count,
    output      logic         busy
);
    logic [W-1:0] cnt_reg;

    // busy stays high for exactly count cycles after the load edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
            busy    <= 1'b0;
        end else if (load) begin
            cnt_reg <= count;
            busy    <= (count != '0);
        end else begin
            if (cnt_reg != '0) begin
                cnt_reg <= cnt_reg - W'(1);
            end
            busy <= (cnt_reg > W'(1));
        end
    end
endmodule

// >>> logic/dqrt_ca_drv.sv
`timescale 1ns/1ps
module dqrt_ca_drv
    import dqrt_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        issue,
    input  wire dqrt_op_e    op,
    input  wire logic [1:0]  bg,
    input  wire logic [1:0]  ba,
    input  wire logic [16:0] row,
    input  wire logic [7:0]  treg,
    output      dqrt_ca_s    ca
);
    // one command cycle per issue, deselect otherwise
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ca <= CA_IDLE;
        end else if (!issue) begin
            ca <= CA_IDLE;
        end else begin
            ca      <= CA_IDLE;
            ca.cs_n <= 1'b0;
            ca.bg   <= bg;
            ca.ba   <= ba;
            ca.addr <= row[13:0];
            case (op)
                OP_ENTER, OP_LEVEL, OP_EXIT: begin
                    ca.ras_n <= 1'b0;
                    ca.cas_n <= 1'b0;
                    ca.we_n  <= 1'b0;
                    ca.bg    <= TREG_BG;
                    ca.ba    <= TREG_BA;
                    ca.addr  <= {6'h00, treg}; // R1
                end
                OP_ACT: begin
                    ca.act_n <= 1'b0;
                    {ca.ras_n, ca.cas_n, ca.we_n} <= row[16:14];
                end
                OP_WR, OP_WRA: begin
                    ca.cas_n        <= 1'b0;
                    ca.we_n         <= 1'b0;
                    ca.addr[AP_BIT] <= (op == OP_WRA);
                end
                OP_RD, OP_RDA: begin
                    ca.cas_n        <= 1'b0;
                    ca.addr[AP_BIT] <= (op == OP_RDA);
                end
                OP_PRE: begin
                    ca.ras_n        <= 1'b0;
                    ca.we_n         <= 1'b0;
                    ca.addr[AP_BIT] <= 1'b0;
                end
                default: begin
                    ca <= CA_IDLE;
                end
            endcase
        end
    end
endmodule

// >>> logic/dqrt_ctrl.sv
`timescale 1ns/1ps
// What this block does
// R1: training register bit 7 set enters training mode, cleared leaves it.
// R2: entry command chooses range with bit 6; level bits ignored.
// R3: six-bit code maps linearly to a reference percentage, highest code 50.
// R4: reserved codes 51 to 63 are never sent.
// R5: after entry, wait the entry delay before any further command.
// R6: in training only activate, write, read, precharge, deselect, training register writes.
// R7: dummy writes are allowed before the first level update after init.
// R8: level updates keep bit 7 high and the entry range, code in low bits.
// R9: device ignores range and code when bit 7 is written low.
// R10: after each level update wait short or long settling by step size; the first update since reset always waits long.
// R11: with per-device addressing in training, only mode register writes.
// R12: device keeps the last range and code written before exit.
// R13: exit only while all banks are idle.
// R14: after exit, only deselect until the exit delay has passed.
// R15: range is chosen only at entry, never changed later.
// R16: end with a final level write, then a write with bit 7 low.
// R17: the entry command never carries a new level.
// R18: before exit, wait the settling time of the latest level step.
// R19: reference is undefined after power-up; train before trusting data input.
// R20: under per-device addressing, low first data bit executes a mode write.
// R21: device holds a training-active flag set by entry, cleared by exit.
// R22: counters time entry, exit and settling waits and hold commands off.
module dqrt_ctrl
    import dqrt_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output      logic [31:0] prdata,
    output      logic        pready,
    output      logic        pslverr,
    output      dqrt_ca_s    ca,
    output      logic        dq0_out,
    output      logic        dq0_oe
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    dqrt_mode_e  mode_reg;
    logic        range_reg;
    logic [5:0]  level_reg;
    logic        level_set_reg;
    logic        level_known_reg;
    logic        first_sess_reg;
    logic        level_valid_reg;
    logic [15:0] bank_open_reg;
    logic [16:0] addr_reg;
    logic        pdev_en_reg;
    logic        pdev_tgt_reg;
    logic        err_ref_reg;
    logic        err_rsv_reg;
    logic        ok_reg;
    logic [7:0]  dq_cnt_reg;

    dqrt_op_e    op;
    logic [5:0]  code;
    logic [3:0]  bidx;
    logic [5:0]  step;
    logic        legal;
    logic        rsv;
    logic        arr_ok;
    logic        setup;
    logic        access;
    logic        issue;
    logic        is_mrs;
    logic        mode_busy;
    logic        settle_busy;
    logic        mode_load;
    logic [7:0]  mode_cnt;
    logic        settle_load;
    logic [7:0]  settle_cnt;
    logic [7:0]  treg;
    logic [31:0] status;

    assign op     = dqrt_op_e'(pwdata[3:0]);
    assign code   = pwdata[CMD_LEVEL_LSB +: 6];
    assign bidx   = {pwdata[CMD_BG_LSB +: 2], pwdata[CMD_BA_LSB +: 2]};
    assign setup  = psel && !penable;
    assign access = psel && penable && pready;
    assign issue  = access && pwrite && (paddr == REG_CMD) && ok_reg;
    assign is_mrs = (op == OP_ENTER) || (op == OP_LEVEL) || (op == OP_EXIT);
    assign step   = (code > level_reg) ? (code - level_reg) : (level_reg - code);

    // ------------------------------------------------------------
    // command legality
    // ------------------------------------------------------------
    always_comb begin
        legal  = 1'b0;
        rsv    = 1'b0;
        arr_ok = !pdev_en_reg && !settle_busy && // R11 R10
                 ((mode_reg == M_NORMAL) || (mode_reg == M_TRAIN)); // R5 R14
        case (op)
            OP_ENTER: begin
                legal = (mode_reg == M_NORMAL);
            end
            OP_LEVEL: begin
                rsv   = (code > LEVEL_MAX); // R4 R3
                legal = (mode_reg == M_TRAIN) && !rsv;
            end
            OP_EXIT: begin
                legal = (mode_reg == M_TRAIN) && !settle_busy && // R18
                        (bank_open_reg == 16'h0000) && level_set_reg; // R13 R16
            end
            OP_ACT: begin
                legal = arr_ok && !bank_open_reg[bidx];
            end
            OP_WR, OP_WRA, OP_RD, OP_RDA: begin
                // dummy writes pass in training before any level is set
                legal = arr_ok && bank_open_reg[bidx] &&
                        (level_valid_reg || (mode_reg == M_TRAIN)); // R19 R7 R6
            end
            OP_PRE: begin
                legal = arr_ok;
            end
            default: begin
                legal = 1'b0;
            end
        endcase
        if (dq_cnt_reg != 8'h00) begin
            legal = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    always_comb begin
        status                  = 32'h0000_0000;
        status[ST_TRAIN]        = (mode_reg != M_NORMAL);
        status[ST_RANGE]        = range_reg;
        status[ST_ENTRY_WAIT]   = (mode_reg == M_ENTRY_WAIT);
        status[ST_SETTLE]       = settle_busy;
        status[ST_EXIT_WAIT]    = (mode_reg == M_EXIT_WAIT);
        status[ST_VALID]        = level_valid_reg;
        status[ST_FIRST]        = first_sess_reg;
        status[ST_BANKS]        = (bank_open_reg != 16'h0000);
        status[ST_LEVEL_LSB +: 6] = level_reg;
        status[ST_ERR_REF]      = err_ref_reg;
        status[ST_ERR_RSV]      = err_rsv_reg;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            ok_reg  <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (setup) begin
                ok_reg  <= legal;
                pslverr <= 1'b0;
                prdata  <= 32'h0000_0000;
                case (paddr)
                    REG_CMD:    pslverr <= pwrite && !legal;
                    REG_ADDR:   prdata  <= {15'h0000, addr_reg};
                    REG_PDEV:   prdata  <= {30'h0, pdev_tgt_reg, pdev_en_reg};
                    REG_STATUS: prdata  <= status;
                    default:    pslverr <= 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_reg    <= 17'h00000;
            pdev_en_reg  <= 1'b0;
            pdev_tgt_reg <= 1'b0;
        end else if (access && pwrite) begin
            if (paddr == REG_ADDR) begin
                addr_reg <= pwdata[16:0];
            end
            if (paddr == REG_PDEV) begin
                pdev_en_reg  <= pwdata[PDEV_EN_BIT];
                pdev_tgt_reg <= pwdata[PDEV_TGT_BIT];
            end
        end
    end

    // sticky errors: write one to clear, a new refusal wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_ref_reg <= 1'b0;
            err_rsv_reg <= 1'b0;
        end else if (access && pwrite) begin
            if (paddr == REG_STATUS) begin
                if (pwdata[ST_ERR_REF]) err_ref_reg <= 1'b0;
                if (pwdata[ST_ERR_RSV]) err_rsv_reg <= 1'b0;
            end
            if (paddr == REG_CMD && !ok_reg) begin
                err_ref_reg <= 1'b1;
                if (rsv) err_rsv_reg <= 1'b1; // R4
            end
        end
    end

    // ------------------------------------------------------------
    // training mode sequencing
    // ------------------------------------------------------------
    assign mode_load   = issue && ((op == OP_ENTER) || (op == OP_EXIT));
    assign mode_cnt    = (op == OP_ENTER) ? ENTRY_CYC : EXIT_CYC; // R22
    assign settle_load = issue && (op == OP_LEVEL);
    assign settle_cnt  = (!level_known_reg || step >= LONG_STEP) ? LONG_CYC : SHORT_CYC; // R10

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= M_NORMAL;
        end else begin
            case (mode_reg)
                M_NORMAL:     if (issue && op == OP_ENTER) mode_reg <= M_ENTRY_WAIT; // R1
                M_ENTRY_WAIT: if (!mode_busy) mode_reg <= M_TRAIN; // R5
                M_TRAIN:      if (issue && op == OP_EXIT) mode_reg <= M_EXIT_WAIT;
                M_EXIT_WAIT:  if (!mode_busy) mode_reg <= M_NORMAL; // R14
                default:      mode_reg <= M_NORMAL;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            range_reg       <= 1'b0;
            level_reg       <= 6'h00;
            level_set_reg   <= 1'b0;
            level_known_reg <= 1'b0;
            first_sess_reg  <= 1'b1;
            level_valid_reg <= 1'b0;
        end else begin
            if (issue && op == OP_ENTER) begin
                range_reg       <= pwdata[CMD_RANGE_BIT]; // R2 R15
                level_set_reg   <= 1'b0;
                level_valid_reg <= 1'b0;
            end
            if (issue && op == OP_LEVEL) begin
                level_reg       <= code;
                level_set_reg   <= 1'b1;
                level_known_reg <= 1'b1;
                first_sess_reg  <= 1'b0; // R7
            end
            if (mode_reg == M_EXIT_WAIT && !mode_busy) begin
                level_valid_reg <= 1'b1; // R19
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bank_open_reg <= 16'h0000;
        end else if (issue) begin
            case (op)
                OP_ACT:               bank_open_reg[bidx] <= 1'b1;
                OP_WRA, OP_RDA, OP_PRE: bank_open_reg[bidx] <= 1'b0;
                default:              bank_open_reg <= bank_open_reg;
            endcase
        end
    end

    always_comb begin
        case (op)
            OP_ENTER: treg = {1'b1, pwdata[CMD_RANGE_BIT], 6'h00}; // R1 R2 R17
            OP_LEVEL: treg = {1'b1, range_reg, code}; // R8 R15
            default:  treg = {1'b0, range_reg, 6'h00}; // R16 R15
        endcase
    end

    // per-device select level is held on the first data bit after each mode write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dq_cnt_reg <= 8'h00;
            dq0_out    <= 1'b1;
            dq0_oe     <= 1'b0;
        end else if (issue && is_mrs && pdev_en_reg) begin
            dq_cnt_reg <= PDEV_CYC;
            dq0_out    <= !pdev_tgt_reg; // R20
            dq0_oe     <= 1'b1;
        end else if (dq_cnt_reg != 8'h00) begin
            dq_cnt_reg <= dq_cnt_reg - 8'h01;
            dq0_oe     <= (dq_cnt_reg != 8'h01);
        end else begin
            dq0_oe <= 1'b0;
        end
    end

    dqrt_timer #(.W(TMR_W)) u_mode_tmr (
        .clk   (pclk),
        .rst_n (presetn),
        .load  (mode_load),
        .count (mode_cnt),
        .busy  (mode_busy)
    );

    dqrt_timer #(.W(TMR_W)) u_settle_tmr (
        .clk   (pclk),
        .rst_n (presetn),
        .load  (settle_load),
        .count (settle_cnt),
        .busy  (settle_busy)
    );

    dqrt_ca_drv u_ca (
        .clk   (pclk),
        .rst_n (presetn),
        .issue (issue),
        .op    (op),
        .bg    (pwdata[CMD_BG_LSB +: 2]),
        .ba    (pwdata[CMD_BA_LSB +: 2]),
        .row   (addr_reg),
        .treg  (treg),
        .ca    (ca)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic       pin_cmd;
    logic       pin_mrs;
    logic       pin_treg;
    logic       pin_arr;
    logic [7:0] gap_cnt;
    logic       gap_arm;
    logic       gap_exit;

    assign pin_cmd = !ca.cs_n;
    assign pin_mrs = pin_cmd && ca.act_n && !ca.ras_n && !ca.cas_n && !ca.we_n;
    assign pin_treg = pin_mrs && ca.bg == TREG_BG && ca.ba == TREG_BA;
    assign pin_arr = pin_cmd && !pin_mrs;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_cnt  <= 8'h00;
            gap_arm  <= 1'b0;
            gap_exit <= 1'b0;
        end else if (pin_treg && $past(mode_reg) != M_TRAIN) begin
            gap_cnt  <= 8'h01;
            gap_arm  <= 1'b1;
            gap_exit <= 1'b0;
        end else if (pin_treg && !ca.addr[TREG_EN_BIT]) begin
            gap_cnt  <= 8'h01;
            gap_arm  <= 1'b1;
            gap_exit <= 1'b1;
        end else if (gap_cnt != 8'hFF) begin
            gap_cnt <= gap_cnt + 8'h01;
        end
    end

    sequence s_entry_pin;
        pin_treg && ca.addr[TREG_EN_BIT] && $past(mode_reg) == M_NORMAL;
    endsequence
    sequence s_exit_pin;
        pin_treg && !ca.addr[TREG_EN_BIT];
    endsequence
    sequence s_level_pin;
        pin_treg && ca.addr[TREG_EN_BIT] && $past(mode_reg) == M_TRAIN;
    endsequence

    a_code_reserved: assert property (pin_treg && ca.addr[TREG_EN_BIT] |-> // R4
        ca.addr[5:0] <= LEVEL_MAX) else $error("reserved level code sent");
    a_entry_quiet: assert property (s_entry_pin |=> !pin_cmd [*8]) // R5
        else $error("command too soon after entry");
    a_exit_quiet: assert property (s_exit_pin |=> !pin_cmd [*8]) // R14
        else $error("command too soon after exit");
    a_gap_count: assert property (pin_cmd && gap_arm |-> // R22
        gap_cnt >= (gap_exit ? EXIT_CYC : ENTRY_CYC))
        else $error("mode delay not counted out");
    a_entry_clean: assert property (s_entry_pin |-> // R17
        ca.addr[5:0] == 6'h00 && ca.addr[TREG_RNG_BIT] == range_reg)
        else $error("entry carried a level");
    a_range_held: assert property (pin_treg && $past(mode_reg) == M_TRAIN |-> // R15
        ca.addr[TREG_RNG_BIT] == $past(range_reg)) else $error("range changed");
    a_exit_idle: assert property (s_exit_pin |-> // R13
        $past(bank_open_reg) == 16'h0000 && $past(level_set_reg))
        else $error("exit with open bank or no level");
    a_pdev_array: assert property (pin_arr |-> !$past(pdev_en_reg)) // R11
        else $error("array command under per-device mode");
    a_settle_exit: assert property (((pin_treg && !ca.addr[TREG_EN_BIT]) || pin_arr) |-> // R18
        !$past(settle_busy)) else $error("settling not met");
    a_level_settle: assert property (s_level_pin |-> settle_busy ##1 settle_busy) // R10
        else $error("settle timer not started");
    a_train_mrs: assert property (pin_mrs && $past(mode_reg) == M_TRAIN |-> pin_treg) // R6
        else $error("illegal mode write in training");
    a_pdev_dq0: assert property (pin_treg && $past(pdev_en_reg) |-> // R20
        dq0_oe && dq0_out == !$past(pdev_tgt_reg))
        else $error("select bit not driven");
endmodule

// >>> verification/dqrt_dev_model.sv
`timescale 1ns/1ps
module dqrt_dev_model
    import dqrt_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire dqrt_ca_s    ca,
    input  wire logic        dq0,
    input  wire logic        pdev_en,
    output      logic        train,
    output      logic [6:0]  treg_q,
    output      logic [13:0] pct
);
    logic       mrs;
    logic [1:0] hit;
    logic [7:0] a0;
    logic [7:0] a1;
    assign mrs = !ca.cs_n && ca.act_n && !ca.ras_n && !ca.cas_n && !ca.we_n
                 && ca.bg == TREG_BG && ca.ba == TREG_BA;
    // reference in hundredths of a percent of the supply
    assign pct = (treg_q[6] ? 14'h1194 : 14'h1770) + 14'(treg_q[5:0]) * 14'h41;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hit   <= 2'h0;
            a0    <= 8'h00;
            a1    <= 8'h00;
            train <= 1'b0;
            treg_q <= 7'h00;
        end else begin
            hit <= {hit[0], mrs};
            a0  <= ca.addr[7:0];
            a1  <= a0;
            // dq0 sampled late, after the pin has been driven for the write
            if (hit[1] && !(pdev_en && dq0)) begin
                train <= a1[7];
                if (a1[7] && train) treg_q <= a1[6:0];
                if (a1[7] && !train) treg_q[6] <= a1[6];
            end
        end
    end
endmodule

// >>> verification/tb.sv
`timescale 1ns/1ps
module tb;
    import dqrt_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pdev_en = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, d;
    logic        pready, pslverr, dq0_out, dq0_oe, dq0, train, e;
    dqrt_ca_s    ca;
    logic [6:0]  treg_q;
    logic [13:0] pct;
    int          error_cnt = 0, samples_checked = 0, cyc = 0;
    dqrt_ctrl i_dqrt_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ca(ca), .dq0_out(dq0_out), .dq0_oe(dq0_oe));
    // released data line is pulled high
    assign dq0 = dq0_oe ? dq0_out : 1'b1;
    dqrt_dev_model i_dqrt_dev_model (.clk(pclk), .rst_n(presetn), .ca(ca), .dq0(dq0),
        .pdev_en(pdev_en), .train(train), .treg_q(treg_q), .pct(pct));
    initial forever #2.5 pclk = ~pclk;
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        samples_checked++;
        if (s !== x) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, x);
        end
    endtask
    task automatic conclude;
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= wd;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        d = prdata; e = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic cmd(input logic [3:0] op, input logic r, input logic [5:0] lv, input logic x);
        bus(1, REG_CMD, {18'h0, lv, 3'h0, r, op});
        chk(32'(e), 32'(x));
    endtask
    task automatic st(input logic [31:0] m, input logic [31:0] x);
        bus(0, REG_STATUS, 32'h0);
        chk(d & m, x);
    endtask
    task automatic wclr(input int b);
        for (int i = 0; i < 200; i++) begin
            bus(0, REG_STATUS, 32'h0);
            if (d[b] === 1'b0) break;
        end
        chk(32'(d[b]), 32'h0);
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            conclude();
        end
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        st(32'h3FFFF, 32'h40);
        bus(0, 12'h010, 32'h0);
        chk(32'(e), 32'h1);
        cmd(2, 0, 5, 1);
        st(32'h10000, 32'h10000);
        bus(1, REG_STATUS, 32'h30000);
        st(32'h30000, 32'h0);
        cmd(1, 1, 5, 0);
        st(32'h7, 32'h7);
        cmd(2, 1, 8, 1);
        chk({train, treg_q}, 8'hC0);
        wclr(2);
        cmd(3, 1, 0, 1);
        cmd(2, 1, 6'h33, 1);
        st(32'h20000, 32'h20000);
        cmd(2, 1, 6'h32, 0);
        st(32'h3F08, 32'h3208);
        cmd(4, 0, 0, 1);
        wclr(3);
        chk(32'(treg_q), 32'h72);
        chk(32'(pct), 32'h1E46);
        cmd(4, 0, 0, 0);
        cmd(5, 0, 0, 0);
        st(32'h80, 32'h80);
        cmd(3, 1, 0, 1);
        cmd(9, 0, 0, 0);
        cmd(3, 1, 0, 0);
        cmd(2, 1, 1, 1);
        wclr(4);
        st(32'h3F23, 32'h3222);
        chk({train, treg_q}, 8'h72);
        pdev_en <= 1;
        bus(1, REG_PDEV, 32'h1);
        cmd(1, 0, 0, 0);
        wclr(2);
        chk(32'(train), 32'h0);
        bus(1, REG_PDEV, 32'h3);
        cmd(2, 0, 7, 0);
        wclr(3);
        chk({train, treg_q}, 8'hB2);
        cmd(4, 0, 0, 1);
        conclude();
    end
endmodule
